// file: wwd_pkg.sv
// constants, state type and register map of the window watchdog
// Functional notes
// - count steps every 16384 clocks, free prescaler phase
// - activated rollover 40h to 3Fh resets system
// - activated reload above window limit resets system
// - activation bit set by software, reset clears
// - software activation: disabled after reset, sticky
// - hardware option forces permanent activation
// - counter keeps counting even when not activated
// - both registers reset to 7Fh
// - window limit bits 6..0, bit 7 reads zero
// - plain halt: one more decrement, then stop
// - halt left by interrupt: restart after delay
// - halt left by reset: back to reset state
// - activated halt with reset option gives system reset
// - active halt: no reset, counter frozen
// - active halt interrupt exit: resume at once
// - active halt reset exit: resume after delay
package wwd_pkg;

    localparam logic [7:0] ADDR_CTRL_COUNT  = 8'h2F;
    localparam logic [7:0] ADDR_WINDOW      = 8'h30;

    localparam int         ACT_BIT          = 7;
    localparam int         COUNT_W          = 7;
    localparam logic [6:0] COUNT_RESET      = 7'h7F;
    localparam logic       ACT_RESET        = 1'b0;
    localparam logic [6:0] WINDOW_RESET     = 7'h7F;
    localparam logic [6:0] ROLL_FROM        = 7'h40;
    localparam logic [6:0] COUNT_STEP       = 7'h01;
    localparam logic [7:0] RDATA_IDLE       = 8'h00;
    localparam logic       RESERVED_BIT     = 1'b0;

    localparam int         PRESC_DIV_DEFAULT = 16384;
    localparam int         PRESC_W           = 14;

    localparam int         DELAY_SHORT_CYCLES = 256;
    localparam int         DELAY_LONG_CYCLES  = 4096;
    localparam int         DELAY_W            = 12;
    localparam logic [11:0] DELAY_SHORT_LOAD  = 12'(DELAY_SHORT_CYCLES - 1);
    localparam logic [11:0] DELAY_LONG_LOAD   = 12'(DELAY_LONG_CYCLES - 1);
    localparam logic [11:0] DELAY_DONE        = 12'h000;
    localparam logic [11:0] DELAY_STEP        = 12'h001;

    // gray codes along run -> halt -> frozen -> delay -> run
    typedef enum logic [2:0] {
        WWD_RUN         = 3'h0,
        WWD_HALT_ARM    = 3'h1,
        WWD_HALT_FROZEN = 3'h3,
        WWD_WAKE_DELAY  = 3'h2,
        WWD_ACTIVE_HALT = 3'h6
    } wwd_state_t;

endpackage

// file: wwd_presc_if.sv
// carrier between watchdog control and its prescaler
`timescale 1ns/100ps
`default_nettype none
interface wwd_presc_if;
    logic run;
    logic tick;
    modport ctrl  (output run, input tick);
    modport presc (input run, output tick);
endinterface
`default_nettype wire

// file: wwd_prescaler.sv
// prescaler giving the downcounter step, advancing only while run is high
`timescale 1ns/100ps
`default_nettype none
module wwd_prescaler
    import wwd_pkg::*;
#(
    parameter int DIV = PRESC_DIV_DEFAULT
) (
    input  wire logic  core_clk,
    input  wire logic  rst_b,
    wwd_presc_if.presc bus
);
    localparam logic [PRESC_W-1:0] LAST = PRESC_W'(DIV - 1);
    localparam logic [PRESC_W-1:0] ZERO = '0;
    localparam logic [PRESC_W-1:0] ONE  = PRESC_W'(1);

    logic [PRESC_W-1:0] phase;
    wire                at_last = (phase == LAST);
    wire  [PRESC_W-1:0] next_phase = at_last ? ZERO : (phase + ONE);

    // never cleared by a count write: phase unknown to software
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            phase    <= ZERO;
            bus.tick <= 1'b0;
        end else begin
            if (bus.run) begin
                phase <= next_phase;
            end
            bus.tick <= bus.run & at_last;
        end
    end
endmodule // wwd_prescaler
`default_nettype wire

// file: wwd_top.sv
// window watchdog: downcounter, window check, halt handling, registers
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module wwd_top
    import wwd_pkg::*;
#(
    parameter int PRESC_DIV = PRESC_DIV_DEFAULT
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    input  wire logic       hw_watchdog_opt,
    input  wire logic       halt_causes_reset_opt,
    input  wire logic       osc_irq_enable,
    input  wire logic       restart_delay_long,
    input  wire logic       halt_req,
    input  wire logic       wake_irq,
    input  wire logic       halt_exit_reset,
    output var  logic       wdg_reset_req,
    output var  logic       halt_mode,
    output var  logic       active_halt_mode,
    output var  logic       count_running
);

    wwd_presc_if presc_bus ();

    wwd_prescaler #(
        .DIV (PRESC_DIV)
    ) u_presc (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .bus      (presc_bus.presc)
    );

    wwd_state_t         state;
    wwd_state_t         next_state;
    logic [6:0]         down_count;
    logic [6:0]         window_limit;
    logic               watchdog_activate;
    logic [DELAY_W-1:0] delay_cnt;

    // register decode
    wire sel_ctrl    = (reg_addr == ADDR_CTRL_COUNT);
    wire sel_win     = (reg_addr == ADDR_WINDOW);
    wire wr_ctrl     = reg_wr & sel_ctrl;
    wire wr_win      = reg_wr & sel_win;
    wire rd_ctrl     = reg_rd & sel_ctrl;
    wire rd_win      = reg_rd & sel_win;
    wire wr_act      = reg_wdata[ACT_BIT];

    wire wdg_active  = watchdog_activate | hw_watchdog_opt;
    wire in_halt     = (state == WWD_HALT_ARM) | (state == WWD_HALT_FROZEN);
    wire counting    = (state == WWD_RUN) | (state == WWD_HALT_ARM);
    wire tick        = presc_bus.tick & counting;

    assign presc_bus.run = counting;

    // reset causes
    wire roll_event  = tick & ~wr_ctrl & (down_count == ROLL_FROM) & wdg_active;
    wire win_violate = wr_ctrl & wdg_active & (down_count > window_limit);
    wire new_active  = wdg_active | wr_act;
    wire sw_msb_clr  = wr_ctrl & new_active & ~reg_wdata[COUNT_W-1];
    wire halt_in_run = halt_req & (state == WWD_RUN);
    wire halt_reset  = halt_in_run & ~osc_irq_enable & halt_causes_reset_opt & wdg_active;
    wire fire        = roll_event | win_violate | sw_msb_clr | halt_reset;

    // halt left through reset goes back to the reset state
    wire halt_clear  = halt_exit_reset & in_halt;

    wire [6:0] dec_count = down_count - COUNT_STEP;
    wire [6:0] next_down_count = halt_clear ? COUNT_RESET :
                                 wr_ctrl    ? reg_wdata[COUNT_W-1:0] :
                                 tick       ? dec_count :
                                              down_count;

    wire next_activate = halt_clear ? ACT_RESET :
                         (watchdog_activate | (wr_ctrl & wr_act));

    wire [6:0] next_window = halt_clear ? WINDOW_RESET :
                             wr_win     ? reg_wdata[COUNT_W-1:0] :
                                          window_limit;

    wire [DELAY_W-1:0] delay_load = restart_delay_long ? DELAY_LONG_LOAD : DELAY_SHORT_LOAD;
    wire               delay_enter = (next_state == WWD_WAKE_DELAY) & (state != WWD_WAKE_DELAY);
    wire               delay_done  = (delay_cnt == DELAY_DONE);
    wire [DELAY_W-1:0] next_delay  = delay_enter ? delay_load :
                                     (state == WWD_WAKE_DELAY) & ~delay_done ? (delay_cnt - DELAY_STEP) :
                                     delay_cnt;

    wire [7:0] next_rdata = rd_ctrl ? {watchdog_activate, down_count} :
                            rd_win  ? {RESERVED_BIT, window_limit} :
                                      RDATA_IDLE;

    wire next_halt_mode   = (next_state == WWD_HALT_ARM) | (next_state == WWD_HALT_FROZEN);
    wire next_active_halt = (next_state == WWD_ACTIVE_HALT);
    wire next_running     = (next_state == WWD_RUN) | (next_state == WWD_HALT_ARM);

    // mode sequencing; a wake event beats a pending step
    always_comb begin
        next_state = state;
        case (state)
            WWD_RUN: begin
                if (halt_in_run & ~halt_reset) begin
                    next_state = osc_irq_enable ? WWD_ACTIVE_HALT : WWD_HALT_ARM;
                end
            end
            WWD_HALT_ARM: begin
                if (wake_irq) begin
                    next_state = WWD_WAKE_DELAY;
                end else if (halt_exit_reset) begin
                    next_state = WWD_RUN;
                end else if (tick) begin
                    next_state = WWD_HALT_FROZEN;
                end
            end
            WWD_HALT_FROZEN: begin
                if (wake_irq) begin
                    next_state = WWD_WAKE_DELAY;
                end else if (halt_exit_reset) begin
                    next_state = WWD_RUN;
                end
            end
            WWD_ACTIVE_HALT: begin
                if (wake_irq) begin
                    next_state = WWD_RUN;
                end else if (halt_exit_reset) begin
                    next_state = WWD_WAKE_DELAY;
                end
            end
            WWD_WAKE_DELAY: begin
                if (delay_done) begin
                    next_state = WWD_RUN;
                end
            end
            default: begin
                next_state = WWD_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state <= WWD_RUN;
            delay_cnt <= DELAY_DONE;
        end else begin
            state <= next_state;
            delay_cnt <= next_delay;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            down_count        <= COUNT_RESET;
            watchdog_activate <= ACT_RESET;
            window_limit      <= WINDOW_RESET;
        end else begin
            down_count        <= next_down_count;
            watchdog_activate <= next_activate;
            window_limit      <= next_window;
        end
    end

    // every output registered so the reset pin logic sees no glitch
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata        <= RDATA_IDLE;
            wdg_reset_req    <= 1'b0;
            halt_mode        <= 1'b0;
            active_halt_mode <= 1'b0;
            count_running    <= 1'b1;
        end else begin
            reg_rdata        <= next_rdata;
            wdg_reset_req    <= fire;
            halt_mode        <= next_halt_mode;
            active_halt_mode <= next_active_halt;
            count_running    <= next_running;
        end
    end

endmodule // wwd_top
`default_nettype wire

// file: wwd_props.sv
// checker: port assertions of the window watchdog
`timescale 1ns/100ps
`default_nettype none
module wwd_props #(
    parameter int PRESC_DIV = 16
) (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       hw_watchdog_opt,
    input wire logic       halt_causes_reset_opt,
    input wire logic       osc_irq_enable,
    input wire logic       restart_delay_long,
    input wire logic       halt_req,
    input wire logic       wake_irq,
    input wire logic       halt_exit_reset,
    input wire logic       wdg_reset_req,
    input wire logic       halt_mode,
    input wire logic       active_halt_mode,
    input wire logic       count_running
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // run state: counting and not armed for halt
    wire run = count_running && !halt_mode;
    chk_window_bit_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h30 |-> !reg_rdata[7]) else $error("window bit 7 read as one");
    chk_plain_halt_entry: assert property (
        halt_req && !osc_irq_enable && !halt_causes_reset_opt && run |=> halt_mode) else $error("halt not entered");
    chk_halt_gives_reset: assert property (
        halt_req && !osc_irq_enable && halt_causes_reset_opt && hw_watchdog_opt && run |=> wdg_reset_req && !halt_mode)
        else $error("halt did not reset");
    chk_active_halt_entry: assert property (
        halt_req && osc_irq_enable && run |=> active_halt_mode && !halt_mode) else $error("active halt not entered");
    chk_active_halt_frozen: assert property (
        active_halt_mode |-> !count_running) else $error("counting in active halt");
    chk_fast_resume: assert property (
        active_halt_mode && wake_irq |=> count_running && !active_halt_mode) else $error("slow resume");
    chk_short_restart: assert property (
        halt_mode && wake_irq && !restart_delay_long |=> !count_running [*8] ##[240:256] count_running)
        else $error("short restart delay wrong");
    chk_reset_exit_delay: assert property (
        active_halt_mode && halt_exit_reset && !wake_irq |=> !count_running [*8]) else $error("no restart delay");
    chk_halt_reset_exit: assert property (
        halt_mode && halt_exit_reset && !wake_irq |=> !halt_mode && count_running) else $error("halt exit wrong");
    chk_hw_msb_clear: assert property (
        hw_watchdog_opt && reg_wr && reg_addr == 8'h2F && !reg_wdata[6] |=> wdg_reset_req) else $error("no reset");
    cov_active_wake: cover property (active_halt_mode && wake_irq);
    cov_halt_exit: cover property (halt_mode && halt_exit_reset);
    cov_reset_pulse: cover property (wdg_reset_req);
endmodule // wwd_props
bind wwd_top wwd_props #(.PRESC_DIV(PRESC_DIV)) i_props (.core_clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .hw_watchdog_opt, .halt_causes_reset_opt, .osc_irq_enable,
    .restart_delay_long, .halt_req, .wake_irq, .halt_exit_reset, .wdg_reset_req, .halt_mode,
    .active_halt_mode, .count_running);
`default_nettype wire

// file: wwd_tb.sv
// self-checking testbench of the window watchdog
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] opt = 4'h0; // hw, halt reset, osc irq, long delay
    logic [2:0] ev = 3'h0; // exit reset, wake, halt
    logic       halt_mode, active_halt_mode, count_running, wdg_reset_req;
    logic [7:0] c1, c2;
    int         fail_count = 0;
    int         n_compared = 0;
    int         n_rst = 0;
    wwd_top #(.PRESC_DIV(16)) i_dut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .hw_watchdog_opt(opt[3]), .halt_causes_reset_opt(opt[2]), .osc_irq_enable(opt[1]),
        .restart_delay_long(opt[0]), .halt_req(ev[0]), .wake_irq(ev[1]), .halt_exit_reset(ev[2]),
        .wdg_reset_req, .halt_mode, .active_halt_mode, .count_running);
    always #4 core_clk = ~core_clk;
    // pulses are one cycle, so count them on the edge
    always @(posedge core_clk) if (wdg_reset_req === 1'b1) n_rst <= n_rst + 1;
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        q = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        rd(a, q);
        cmp("register", e, q);
    endtask
    task automatic pls(input logic [2:0] v);
        ev <= v;
        @(posedge core_clk);
        ev <= 3'h0;
    endtask
    // status bits: halt, active halt, running
    task automatic st(input logic [2:0] e);
        @(negedge core_clk);
        cmp("status", {5'h00, e}, {5'h00, halt_mode, active_halt_mode, count_running});
        @(posedge core_clk);
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        fail_count++;
        end_of_test;
    end
    initial begin
        cyc(16);
        rst_b <= 1'b1;
        cyc(1);
        rc(8'h2F, 8'h7F);
        rc(8'h30, 8'h7F);
        wr(8'h30, 8'hD0);
        rc(8'h30, 8'h50);
        wr(8'h31, 8'hFF);
        rc(8'h31, 8'h00);
        rd(8'h2F, c1);
        // reads are alike, so sample points lie exactly 70 periods apart
        cyc(16 * 70 - 2);
        rd(8'h2F, c2);
        cmp("steps", 8'h46, c1 - c2);
        cmp("resets", 8'h00, n_rst[7:0]);
        wr(8'h2F, 8'hFF);
        cyc(1);
        wr(8'h2F, 8'hFF);
        cyc(3);
        cmp("resets", 8'h01, n_rst[7:0]);
        wr(8'h2F, 8'h7F);
        rd(8'h2F, c1);
        cmp("active", 8'h80, c1 & 8'h80);
        cyc(16 * 50);
        wr(8'h2F, 8'hFF);
        cyc(3);
        cmp("resets", 8'h02, n_rst[7:0]);
        cyc(16 * 66);
        cmp("resets", 8'h03, n_rst[7:0]);
        rst_b <= 1'b0;
        cyc(16);
        rst_b <= 1'b1;
        cyc(1);
        rd(8'h2F, c1);
        cmp("active", 8'h00, c1 & 8'h80);
        wr(8'h30, 8'h50);
        cyc(1);
        wr(8'h2F, 8'h7F);
        pls(3'h1);
        cyc(40);
        st(3'h4);
        rd(8'h2F, c1);
        cyc(100);
        rd(8'h2F, c2);
        cmp("frozen", c1, c2);
        // prescaler restarts from reset, so the single halt step is known
        cmp("halt step", 8'h7E, c1);
        pls(3'h2);
        cyc(200);
        st(3'h0);
        cyc(70);
        st(3'h1);
        pls(3'h1);
        cyc(1);
        pls(3'h4);
        st(3'h1);
        rc(8'h30, 8'h7F);
        opt <= 4'hC;
        wr(8'h2F, 8'h7F);
        pls(3'h1);
        st(3'h1);
        wr(8'h2F, 8'h3F);
        cyc(3);
        cmp("resets", 8'h05, n_rst[7:0]);
        wr(8'h2F, 8'h7F);
        opt <= 4'hF;
        pls(3'h1);
        st(3'h2);
        rd(8'h2F, c1);
        cyc(50);
        rd(8'h2F, c2);
        cmp("held", c1, c2);
        pls(3'h2);
        @(negedge core_clk);
        cmp("running", 8'h01, {7'h00, count_running});
        pls(3'h1);
        cyc(1);
        pls(3'h4);
        cyc(4000);
        st(3'h0);
        cyc(200);
        st(3'h1);
        cmp("resets", 8'h05, n_rst[7:0]);
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
